// ---- design/periodic_timebase_interrupt.sv ----
// periodic timebase: divider chain on the oscillator clock with tap-selected tick flag
// assumes one pclk domain; oscillator_clock is an asynchronous pin, much slower than pclk
//
// Design decisions made here: the register offsets and the APB slave port.
`include "tick_map.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE1: divider counts edges of oscillator clock
// RULE2: counter held zero while disabled
// RULE3: counting starts once enable set
// RULE4: tap codes give 32768 down to 8
// RULE5: tap overflow sets pending flag
// RULE6: pending and irq enable raise cpu request
// RULE7: writing one to acknowledge clears flag
// RULE8: acknowledge bit always reads zero
// RULE9: first flag at half period, then full
// RULE10: disable then enable restarts from zero
// RULE11: reset clears enable and irq enable
// RULE12: keeps running in wait mode
// RULE13: in stop, runs only with oscillator kept
// RULE14: tick in stop wakes the processor
// RULE15: control register closed in wait, stop
// RULE16: software changes tap only while disabled; the block does not block a tap write while running
// RULE17: request stands until flag acknowledged
module periodic_timebase_interrupt
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock source and power state
  input wire logic oscillator_clock,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic osc_run_in_stop,
  // requests
  output logic tick_irq_request,
  output logic stop_wakeup,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus request and decode

  tick_pkg::apb_req_type req;
  tick_pkg::access_type access_kind;
  wire setup_phase;
  wire access_phase;
  wire hit_ctrl;
  wire hit_status;
  wire hit_clear;
  wire hit_irq_en;
  wire mapped;
  wire low_power;

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign setup_phase = req.sel && !req.enable;
  assign access_phase = req.sel && req.enable;
  assign hit_ctrl = (req.addr == `TB_CTRL_OFFSET);
  assign hit_status = (req.addr == `TB_STATUS_OFFSET);
  assign hit_clear = (req.addr == `TB_CLEAR_OFFSET);
  assign hit_irq_en = (req.addr == `TB_IRQ_EN_OFFSET);
  assign mapped = hit_ctrl || hit_status || hit_clear || hit_irq_en;
  assign low_power = wait_mode || stop_mode;

  // classification fixed at setup so the answer cannot flip mid-transfer
  tick_pkg::access_type access_nxt;
  assign access_nxt = !setup_phase ? tick_pkg::ACC_IDLE
                    : !mapped ? tick_pkg::ACC_UNMAPPED
                    : (hit_ctrl && low_power) ? tick_pkg::ACC_BLOCKED // RULE15
                    : tick_pkg::ACC_OK;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      access_kind <= tick_pkg::ACC_IDLE;
    else if (setup_phase)
      access_kind <= access_nxt;
  end

  wire do_write;
  assign do_write = access_phase && req.write && (access_kind == tick_pkg::ACC_OK);

  wire wr_ctrl;
  wire wr_clear;
  wire wr_irq_en;
  assign wr_ctrl = do_write && hit_ctrl;
  assign wr_clear = do_write && hit_clear;
  assign wr_irq_en = do_write && hit_irq_en;

  ////////////////////////////////////////////////////////////////////////////////
  // control register

  tick_pkg::control_type ctrl_r;
  tick_pkg::control_type ctrl_nxt;

  assign ctrl_nxt = wr_ctrl
    ? '{tap_select: req.wdata[`TB_CTRL_TAP_MSB:`TB_CTRL_TAP_LSB],
        tick_irq_enable: req.wdata[`TB_CTRL_IRQ_EN_BIT],
        tick_enable: req.wdata[`TB_CTRL_ENABLE_BIT]}
    : ctrl_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= tick_pkg::control_type'(`TB_CTRL_RESET); // RULE11
    else
      ctrl_r <= ctrl_nxt;
  end

  wire ack_write;
  assign ack_write = wr_ctrl && req.wdata[`TB_CTRL_ACK_BIT]; // RULE7

  ////////////////////////////////////////////////////////////////////////////////
  // oscillator edge detection
  // three stages; a level counts only once the last two agree

  logic [`TB_SYNC_STAGES-1:0] osc_sync_r;
  logic osc_level_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_sync_r <= '0;
    else
      osc_sync_r <= {osc_sync_r[`TB_SYNC_STAGES-2:0], oscillator_clock};
  end

  wire osc_agree;
  wire tick_source_clock;
  assign osc_agree = (osc_sync_r[1] == osc_sync_r[2]);
  assign tick_source_clock = osc_agree && osc_sync_r[2] && !osc_level_r; // RULE1

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_level_r <= 1'b0;
    else if (osc_agree)
      osc_level_r <= osc_sync_r[2];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // divider chain

  localparam int CW = `TB_COUNT_WIDTH;

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic [CW-1:0] count_inc;
  wire osc_alive;
  wire run_tick;

  // oscillator halts in stop unless kept alive, so the chain sits still
  assign osc_alive = !stop_mode || osc_run_in_stop; // RULE13
  // wait mode does not gate the chain
  assign run_tick = ctrl_r.tick_enable && osc_alive && tick_source_clock; // RULE12
  assign count_inc = count_r + CW'(1);
  assign count_nxt = !ctrl_r.tick_enable ? `TB_COUNT_RESET // RULE2 RULE10
                   : run_tick ? count_inc // RULE3
                   : count_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= `TB_COUNT_RESET;
    else
      count_r <= count_nxt;
  end

  // bit that rises at half the divide ratio; tap changes while running are not guarded
  function automatic logic [3:0] tap_index(input logic [2:0] sel);
    logic [3:0] idx;
    idx = 4'hE;
    case (sel)
      3'h0: idx = 4'hE;
      3'h1: idx = 4'hC;
      3'h2: idx = 4'hA;
      3'h3: idx = 4'h6;
      3'h4: idx = 4'h5;
      3'h5: idx = 4'h4;
      3'h6: idx = 4'h3;
      3'h7: idx = 4'h2;
      default: idx = 4'hE;
    endcase
    return idx;
  endfunction

  wire [3:0] tap_bit;
  wire tap_event;
  assign tap_bit = tap_index(ctrl_r.tap_select); // RULE4 RULE16
  // rising tap bit: first after half a period, then once per full period
  assign tap_event = run_tick && !count_r[tap_bit] && count_inc[tap_bit]; // RULE9

  ////////////////////////////////////////////////////////////////////////////////
  // pending flag and cpu request

  logic pending_r;
  wire pending_nxt;
  // a new overflow beats an acknowledge in the same cycle
  assign pending_nxt = tap_event || (pending_r && !ack_write); // RULE5 RULE7

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending_r <= 1'b0;
    else
      pending_r <= pending_nxt;
  end

  assign tick_irq_request = pending_r && ctrl_r.tick_irq_enable; // RULE6 RULE17

  logic wakeup_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wakeup_r <= 1'b0;
    else
      wakeup_r <= tap_event && stop_mode; // RULE14
  end
  assign stop_wakeup = wakeup_r;

  ////////////////////////////////////////////////////////////////////////////////
  // event status, clear and enable

  logic [`TB_EVT_WIDTH-1:0] evt_status_r;
  logic [`TB_EVT_WIDTH-1:0] evt_enable_r;
  logic [`TB_EVT_WIDTH-1:0] evt_set;
  logic [`TB_EVT_WIDTH-1:0] evt_clr;
  wire blocked_access;

  assign blocked_access = access_phase && (access_kind == tick_pkg::ACC_BLOCKED);
  assign evt_set = {blocked_access, wakeup_r, tap_event};
  assign evt_clr = wr_clear ? req.wdata[`TB_EVT_WIDTH-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_status_r <= `TB_EVT_RESET;
      evt_enable_r <= `TB_EVT_RESET;
    end
    else
    begin
      evt_status_r <= evt_set | (evt_status_r & ~evt_clr);
      evt_enable_r <= wr_irq_en ? req.wdata[`TB_EVT_WIDTH-1:0] : evt_enable_r;
    end
  end

  assign irq = |(evt_status_r & evt_enable_r);

  ////////////////////////////////////////////////////////////////////////////////
  // read data, taken at setup so prdata comes from a flop

  wire [31:0] ctrl_view;
  wire [31:0] rd_mux;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // acknowledge position left at zero
  assign ctrl_view = {24'h000000, pending_r, ctrl_r.tap_select, 1'b0,
                      ctrl_r.tick_irq_enable, ctrl_r.tick_enable, 1'b0}; // RULE8
  assign rd_mux = (access_nxt != tick_pkg::ACC_OK) ? 32'h00000000
                : hit_ctrl ? ctrl_view
                : hit_status ? {29'h00000000, evt_status_r}
                : hit_irq_en ? {29'h00000000, evt_enable_r}
                : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_r <= (access_nxt != tick_pkg::ACC_OK);
    end
  end

  assign prdata = prdata_r;
  assign pready = access_phase;
  assign pslverr = access_phase && pslverr_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  property p_hold_zero;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_r.tick_enable |=> count_r == '0;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("counter not zero while off"); // RULE2

  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
    ctrl_r.tick_enable && !wr_ctrl && tick_source_clock && !stop_mode
      |=> count_r == $past(count_r) + CW'(1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter missed an edge"); // RULE3

  property p_wait_runs;
    @(posedge pclk) disable iff (!presetn)
    wait_mode && !stop_mode && ctrl_r.tick_enable && !wr_ctrl && tick_source_clock
      |=> count_r != $past(count_r);
  endproperty
  a_wait_runs: assert property (p_wait_runs) else $error("counter idle in wait"); // RULE12

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
    tap_event |=> pending_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow did not set flag"); // RULE5

  property p_div8_phase;
    @(posedge pclk) disable iff (!presetn)
    tap_event && ctrl_r.tap_select == 3'h7 |-> count_r[2:0] == 3'h3;
  endproperty
  a_div8_phase: assert property (p_div8_phase) else $error("tap fired at wrong count"); // RULE9

  property p_ack_clear;
    @(posedge pclk) disable iff (!presetn)
    ack_write && !tap_event |=> !pending_r ##0 !tick_irq_request;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("acknowledge left flag set"); // RULE7

  property p_ack_zero_keeps;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl && !req.wdata[`TB_CTRL_ACK_BIT] && pending_r |=> pending_r;
  endproperty
  a_ack_zero_keeps: assert property (p_ack_zero_keeps) // RULE7
    else $error("zero write cleared flag");

  property p_ack_reads_zero;
    @(posedge pclk) disable iff (!presetn)
    access_phase && !pwrite && hit_ctrl |-> !prdata[`TB_CTRL_ACK_BIT];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) // RULE8
    else $error("acknowledge read as one");

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
    $rose(pending_r) && ctrl_r.tick_irq_enable |-> tick_irq_request [*1] ##1
      (tick_irq_request || !pending_r || !ctrl_r.tick_irq_enable);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("cpu request dropped early"); // RULE6

  property p_stop_idle;
    @(posedge pclk) disable iff (!presetn)
    stop_mode && !osc_run_in_stop && ctrl_r.tick_enable && !wr_ctrl |=> $stable(count_r);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("counter ran in stop"); // RULE13

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
    tap_event && stop_mode |=> stop_wakeup ##1 evt_status_r[`TB_EVT_WAKE_BIT];
  endproperty
  a_wake: assert property (p_wake) else $error("no wakeup from stop"); // RULE14

  property p_closed_low_power;
    @(posedge pclk) disable iff (!presetn)
    setup_phase && hit_ctrl && low_power ##1 access_phase |-> pslverr ##1 $stable(ctrl_r);
  endproperty
  a_closed_low_power: assert property (p_closed_low_power) // RULE15
    else $error("control reached in low power");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    $rose(ctrl_r.tick_enable) |-> count_r == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("counter kept value over restart"); // RULE10

endmodule

// ---- design/tick_map.svh ----
// register offsets, field positions, reset values and counter and synchronizer sizes of the timebase
// assumes a 32-bit apb slave with one aligned word per register
`ifndef TICK_MAP_SVH
`define TICK_MAP_SVH

`define TB_CTRL_OFFSET 12'h000
`define TB_STATUS_OFFSET 12'h004
`define TB_CLEAR_OFFSET 12'h008
`define TB_IRQ_EN_OFFSET 12'h00C

`define TB_CTRL_ENABLE_BIT 1
`define TB_CTRL_IRQ_EN_BIT 2
`define TB_CTRL_ACK_BIT 3
`define TB_CTRL_TAP_LSB 4
`define TB_CTRL_TAP_MSB 6
`define TB_CTRL_PENDING_BIT 7

`define TB_EVT_TICK_BIT 0
`define TB_EVT_WAKE_BIT 1
`define TB_EVT_BLOCKED_BIT 2
`define TB_EVT_WIDTH 3

`define TB_CTRL_RESET 8'h00
`define TB_EVT_RESET 3'h0
`define TB_COUNT_RESET 15'h0000

`define TB_COUNT_WIDTH 15
`define TB_SYNC_STAGES 3

`endif

// ---- design/tick_pkg.sv ----
// types used by the timebase block; the bench does not import them
// assumes tick_map.svh for the numeric layout
package tick_pkg;

  typedef struct packed {
    logic [2:0] tap_select;
    logic tick_irq_enable;
    logic tick_enable;
  } control_type;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_type;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_OK = 2'b01,
    ACC_BLOCKED = 2'b10,
    ACC_UNMAPPED = 2'b11
  } access_type;

endpackage

// ---- testbench/test_periodic_timebase_interrupt.sv ----
// bench for the periodic timebase: apb register access, tap timing, low power modes
// assumes the design files are compiled first; the oscillator runs here at pclk/8
module test_periodic_timebase_interrupt;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [2:0] code;
    int lim;
    int lo;
    int hi;
    int full;
  } row_type;

  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic oscillator_clock = 1'h0;
  logic wait_mode = 1'h0;
  logic stop_mode = 1'h0;
  logic osc_run_in_stop = 1'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tick_irq_request;
  logic stop_wakeup;
  logic irq;
  logic [1:0] osc_div = 2'h0;
  logic [31:0] rd;
  logic err;
  int osc_edges = 0;
  int cycles = 0;
  int fail_count = 0;
  int checked = 0;
  int n;
  int t1;
  row_type rows[8];

  periodic_timebase_interrupt i_periodic_timebase_interrupt (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscillator_clock(oscillator_clock), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .osc_run_in_stop(osc_run_in_stop), .tick_irq_request(tick_irq_request),
    .stop_wakeup(stop_wakeup), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always #4 pclk = ~pclk;

  // oscillator at the 8 pclk minimum period; slower would stretch the run
  always @(posedge pclk)
  begin
    osc_div <= osc_div + 2'h1;
    if (osc_div == 2'h3)
    begin
      oscillator_clock <= ~oscillator_clock;
      if (!oscillator_clock)
        osc_edges <= osc_edges + 1;
    end
  end

  always @(posedge pclk)
  begin
    cycles = cycles + 1;
    if (cycles == 90000)
    begin
      fail_count = fail_count + 1;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic check_num(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("[ERR] %0t edges %0d expected %0d to %0d", $time, got, lo, hi);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'h0, a, 32'h00000000);
    check_word(rd, exp);
    check_bit(err, exp_err);
  endtask

  // counts oscillator edges until the request (or the wake pulse) shows, or the limit
  task automatic wait_req(input int lim, input logic wake, output int cnt);
    int s;
    s = osc_edges;
    while (((wake ? stop_wakeup : tick_irq_request) !== 1'h1) && osc_edges - s < lim)
      @(posedge pclk);
    cnt = osc_edges - s;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // the next two largest taps are only timed to their first flag and the largest only checked silent for 4200 edges, to bound the run
    rows = '{'{3'h7, 40, 3, 5, 8}, '{3'h6, 40, 7, 9, 16}, '{3'h5, 60, 15, 17, 32},
      '{3'h4, 100, 31, 33, 64}, '{3'h3, 200, 63, 65, 128}, '{3'h2, 1100, 1023, 1025, 0},
      '{3'h1, 4200, 4095, 4097, 0}, '{3'h0, 4200, 4200, 4200, 0}};
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    rd_reg(12'h000, 32'h00000000, 1'h0);
    rd_reg(12'h004, 32'h00000000, 1'h0);
    rd_reg(12'h00C, 32'h00000000, 1'h0);
    rd_reg(12'h010, 32'h00000000, 1'h1);
    foreach (rows[i])
    begin
      wr_reg(12'h000, {25'h0, rows[i].code, 4'h6});
      wait_req(rows[i].lim, 1'h0, n);
      t1 = osc_edges;
      check_num(n, rows[i].lo, rows[i].hi);
      if (rows[i].full > 0)
      begin
        rd_reg(12'h000, {24'h0, 1'h1, rows[i].code, 4'h6}, 1'h0);
        wr_reg(12'h000, {25'h0, rows[i].code, 4'hE});
        @(negedge pclk);
        check_bit(tick_irq_request, 1'h0);
        wait_req(rows[i].full + 4, 1'h0, n);
        check_num(osc_edges - t1, rows[i].full, rows[i].full);
      end
      wr_reg(12'h000, 32'h00000008);
    end
    wr_reg(12'h000, 32'h00000072);
    repeat (80) @(posedge pclk);
    rd_reg(12'h000, 32'h000000F2, 1'h0);
    check_bit(tick_irq_request, 1'h0);
    wr_reg(12'h000, 32'h00000076);
    @(negedge pclk);
    check_bit(tick_irq_request, 1'h1);
    wr_reg(12'h000, 32'h00000008);
    // a flag landing with the disabling write beats its acknowledge; clear it once stopped
    wr_reg(12'h000, 32'h00000008);
    rd_reg(12'h004, 32'h00000001, 1'h0);
    wr_reg(12'h00C, 32'h00000001);
    @(negedge pclk);
    check_bit(irq, 1'h1);
    wr_reg(12'h00C, 32'h00000000);
    @(negedge pclk);
    check_bit(irq, 1'h0);
    wr_reg(12'h008, 32'h00000007);
    rd_reg(12'h004, 32'h00000000, 1'h0);
    // restart: a counter that kept its count would flag after one edge
    wr_reg(12'h000, 32'h00000076);
    repeat (16) @(posedge pclk);
    wr_reg(12'h000, 32'h00000000);
    wr_reg(12'h000, 32'h00000076);
    wait_req(40, 1'h0, n);
    check_num(n, 3, 5);
    wr_reg(12'h000, 32'h00000008);
    wr_reg(12'h000, 32'h00000076);
    wait_mode <= 1'h1;
    wait_req(40, 1'h0, n);
    check_num(n, 3, 5);
    rd_reg(12'h000, 32'h00000000, 1'h1);
    wr_reg(12'h000, 32'h00000008);
    @(negedge pclk);
    check_bit(tick_irq_request, 1'h1);
    rd_reg(12'h004, 32'h00000005, 1'h0);
    wait_mode <= 1'h0;
    wr_reg(12'h000, 32'h00000008);
    wr_reg(12'h000, 32'h00000008);
    wr_reg(12'h000, 32'h00000076);
    stop_mode <= 1'h1;
    wait_req(40, 1'h0, n);
    check_num(n, 40, 40);
    osc_run_in_stop <= 1'h1;
    wait_req(40, 1'h1, n);
    check_num(n, 3, 5);
    stop_mode <= 1'h0;
    osc_run_in_stop <= 1'h0;
    rd_reg(12'h004, 32'h00000007, 1'h0);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd_reg(12'h000, 32'h00000000, 1'h0);
    check_bit(tick_irq_request, 1'h0);
    report_and_stop();
  end
endmodule
